/* File: core/acr_defs.vh */
// Purpose: constants for the converter control and result register block
// Assumes: AXI4-Lite register map, 32-bit data, byte addresses
// Notes: definitions only
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH
`define ACR_OFF_CFG 4'h0
`define ACR_OFF_TRG 4'h1
`define ACR_OFF_CHM 4'h2
`define ACR_OFF_RESH 4'h3
`define ACR_OFF_RESL 4'h4
`define ACR_OFF_CMPH 4'h5
`define ACR_OFF_CMPL 4'h6
`define ACR_OFF_PINL 4'h7
`define ACR_OFF_PINH 4'h8
`define ACR_CFG_LP 7
`define ACR_CFG_DIV_HI 6
`define ACR_CFG_DIV_LO 5
`define ACR_CFG_LSMP 4
`define ACR_CFG_MODE_HI 3
`define ACR_CFG_MODE_LO 2
`define ACR_CFG_CLK_HI 1
`define ACR_CFG_CLK_LO 0
`define ACR_TRG_ACT 7
`define ACR_TRG_HW 6
`define ACR_TRG_CFE 5
`define ACR_TRG_CGT 4
`define ACR_CHM_DONE 7
`define ACR_CHM_IEN 6
`define ACR_CHM_CONT 5
`define ACR_MODE_8 2'h0
`define ACR_MODE_10 2'h2
`define ACR_CLK_BUS 2'h0
`define ACR_CLK_BUS2 2'h1
`define ACR_CLK_ALT 2'h2
`define ACR_CLK_ASYNC 2'h3
`define ACR_RST_CFG 8'h00
`define ACR_RST_TRG 8'h00
`define ACR_RST_CHM 8'h1f
`define ACR_RST_BYTE 8'h00
`define ACR_SMP_SHORT 8'h03
`define ACR_SMP_LONG 8'h17
`define ACR_BITS_8 4'h8
`define ACR_BITS_10 4'ha
`define ACR_ASYNC_DIV 4'h9
`define ACR_RESP_OKAY 2'h0
`define ACR_RESP_SLVERR 2'h2
`endif

/* File: core/acr_regs.v */
// Purpose: register file and conversion sequencer of a successive-approximation converter
// Assumes: i_analog_code is the comparator's ideal code of the sampled input, 10 bits
// Notes: samples count in whole conversion-clock cycles, one more than the loaded count
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.vh"
module acr_regs #(
    parameter CHANNELS = 16
)
(
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire [31:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output reg o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output reg o_s_axi_wready,
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [31:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output reg o_s_axi_arready,
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready,
    input wire i_hw_trigger,
    input wire i_alt_clk,
    input wire [9:0] i_analog_code,
    output reg [4:0] o_sample_channel,
    output reg o_sampling,
    output reg o_low_power,
    output reg o_irq,
    output reg [CHANNELS-1:0] o_pin_analog
);
    reg [7:0] cfg_q;
    reg [7:0] trg_q;
    reg [7:0] chm_q;
    reg [7:0] resh_q;
    reg [7:0] resl_q;
    reg [7:0] cmph_q;
    reg [7:0] cmpl_q;
    reg [7:0] pinl_q;
    reg [7:0] pinh_q;
    reg done_q;
    reg hold_q;
    reg [31:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg aw_have_q;
    reg w_have_q;
    // external level inputs pass two flops first
    reg [1:0] trg_sync_q;
    reg [1:0] alt_sync_q;
    reg [9:0] code_s1_q;
    reg [9:0] code_s2_q;
    reg trg_prev_q;
    reg alt_prev_q;
    reg [3:0] async_cnt_q;
    reg [2:0] div_cnt_q;
    reg bus2_q;
    // conversion sequencer
    localparam ST_IDLE = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_CONVERT = 2'h2;
    localparam ST_FINISH = 2'h3;
    reg [1:0] state_q;
    reg [7:0] cnt_q;
    reg [9:0] sar_q;
    reg [9:0] code_q;
    wire [3:0] reg_idx_w = awaddr_q[5:2];
    wire wr_fire = aw_have_q && w_have_q && !o_s_axi_bvalid;
    wire wr_ok = (awaddr_q[31:6] == 26'h0) && (reg_idx_w <= `ACR_OFF_PINH);
    wire wr_chm = wr_fire && wr_ok && (reg_idx_w == `ACR_OFF_CHM) && wstrb_q[0];
    wire [3:0] rd_idx_w = i_s_axi_araddr[5:2];
    wire rd_fire = i_s_axi_arvalid && o_s_axi_arready;
    wire rd_ok = (i_s_axi_araddr[31:6] == 26'h0) && (rd_idx_w <= `ACR_OFF_PINH);
    wire rd_low = rd_fire && rd_ok && (rd_idx_w == `ACR_OFF_RESL);
    wire mode10 = (cfg_q[`ACR_CFG_MODE_HI:`ACR_CFG_MODE_LO] == `ACR_MODE_10);
    wire [1:0] clk_sel = cfg_q[`ACR_CFG_CLK_HI:`ACR_CFG_CLK_LO];
    reg src_tick;
    always @*
    begin
        case (clk_sel)
            `ACR_CLK_BUS: src_tick = 1'b1;
            `ACR_CLK_BUS2: src_tick = bus2_q;
            `ACR_CLK_ALT: src_tick = alt_sync_q[1] && !alt_prev_q;
            default: src_tick = (async_cnt_q == 4'h0);
        endcase
    end
    // divide ratio 1,2,4,8 from the selected source
    wire [2:0] div_mask = (3'h1 << cfg_q[`ACR_CFG_DIV_HI:`ACR_CFG_DIV_LO]) - 3'h1;
    wire conversion_clock = src_tick && ((div_cnt_q & div_mask) == 3'h0);
    wire hw_edge = trg_sync_q[1] && !trg_prev_q;
    wire hw_mode = trg_q[`ACR_TRG_HW];
    wire start_sw = wr_chm && !hw_mode;
    wire start_hw = hw_mode && hw_edge;
    wire [9:0] cmp_val = mode10 ? {cmph_q[1:0], cmpl_q} : {2'h0, cmpl_q};
    // result less compare value, two's complement add, kept for the result pair
    wire [9:0] diff = code_q + (~cmp_val + 10'h001);
    wire cmp_true = trg_q[`ACR_TRG_CGT] ? (code_q >= cmp_val) : (code_q < cmp_val);
    wire pass = !trg_q[`ACR_TRG_CFE] || cmp_true;
    wire [9:0] res_val = trg_q[`ACR_TRG_CFE] ? diff : code_q;
    wire [3:0] nbits = mode10 ? `ACR_BITS_10 : `ACR_BITS_8;
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            trg_sync_q <= 2'h0;
            alt_sync_q <= 2'h0;
            code_s1_q <= 10'h000;
            code_s2_q <= 10'h000;
            trg_prev_q <= 1'b0;
            alt_prev_q <= 1'b0;
            async_cnt_q <= 4'h0;
            div_cnt_q <= 3'h0;
            bus2_q <= 1'b0;
        end
        else
        begin
            trg_sync_q <= {trg_sync_q[0], i_hw_trigger};
            alt_sync_q <= {alt_sync_q[0], i_alt_clk};
            code_s1_q <= i_analog_code;
            code_s2_q <= code_s1_q;
            trg_prev_q <= trg_sync_q[1];
            alt_prev_q <= alt_sync_q[1];
            async_cnt_q <= (async_cnt_q == `ACR_ASYNC_DIV) ? 4'h0 : async_cnt_q + 4'h1;
            bus2_q <= !bus2_q;
            if (src_tick)
            begin
                div_cnt_q <= div_cnt_q + 3'h1;
            end
        end
    end
    // sequencer; sample counts short or long, then one step per result bit
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            sar_q <= 10'h000;
            code_q <= 10'h000;
        end
        else if (start_sw || start_hw)
        begin
            // a new start aborts any running conversion
            state_q <= ST_SAMPLE;
            cnt_q <= cfg_q[`ACR_CFG_LSMP] ? `ACR_SMP_LONG : `ACR_SMP_SHORT;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= 8'h00;
                end
                ST_SAMPLE:
                begin
                    if (conversion_clock)
                    begin
                        if (cnt_q == 8'h00)
                        begin
                            state_q <= ST_CONVERT;
                            cnt_q <= {4'h0, nbits};
                            // channel need not be pin-enabled to convert
                            sar_q <= code_s2_q;
                        end
                        else
                        begin
                            cnt_q <= cnt_q - 8'h01;
                        end
                    end
                end
                ST_CONVERT:
                begin
                    if (conversion_clock)
                    begin
                        if (cnt_q == 8'h01)
                        begin
                            state_q <= ST_FINISH;
                            // scale to the resolution, 8-bit mode keeps the upper eight bits
                            code_q <= mode10 ? sar_q : {2'h0, sar_q[9:2]};
                        end
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_FINISH:
                begin
                    if (chm_q[`ACR_CHM_CONT])
                    begin
                        state_q <= ST_SAMPLE;
                        cnt_q <= cfg_q[`ACR_CFG_LSMP] ? `ACR_SMP_LONG : `ACR_SMP_SHORT;
                    end
                    else
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
    wire finish = (state_q == ST_FINISH);
    wire transfer = finish && pass && !hold_q;
    // axi write channel
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `ACR_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (i_s_axi_awvalid && o_s_axi_awready)
            begin
                awaddr_q <= i_s_axi_awaddr;
                aw_have_q <= 1'b1;
                o_s_axi_awready <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready)
            begin
                wdata_q <= i_s_axi_wdata;
                wstrb_q <= i_s_axi_wstrb;
                w_have_q <= 1'b1;
                o_s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= wr_ok ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            if (o_s_axi_bvalid && i_s_axi_bready)
            begin
                o_s_axi_bvalid <= 1'b0;
                o_s_axi_awready <= 1'b1;
                o_s_axi_wready <= 1'b1;
            end
        end
    end
    // register writes, done flag and result hold
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cfg_q <= `ACR_RST_CFG;
            trg_q <= `ACR_RST_TRG;
            chm_q <= `ACR_RST_CHM;
            cmph_q <= `ACR_RST_BYTE;
            cmpl_q <= `ACR_RST_BYTE;
            pinl_q <= `ACR_RST_BYTE;
            pinh_q <= `ACR_RST_BYTE;
            resh_q <= `ACR_RST_BYTE;
            resl_q <= `ACR_RST_BYTE;
            done_q <= 1'b0;
            hold_q <= 1'b0;
        end
        else
        begin
            if (wr_fire && wr_ok && wstrb_q[0])
            begin
                case (reg_idx_w)
                    `ACR_OFF_CFG: cfg_q <= wdata_q[7:0];
                    // bits 3:0 stored as zero, software keeps 1:0 at zero
                    `ACR_OFF_TRG: trg_q <= {1'b0, wdata_q[6:4], 4'h0};
                    `ACR_OFF_CHM: chm_q <= {1'b0, wdata_q[6:0]};
                    `ACR_OFF_CMPH: cmph_q <= {6'h00, wdata_q[1:0]};
                    `ACR_OFF_CMPL: cmpl_q <= wdata_q[7:0];
                    `ACR_OFF_PINL: pinl_q <= wdata_q[7:0];
                    `ACR_OFF_PINH: pinh_q <= wdata_q[7:0];
                    default: ;
                endcase
            end
            // reading the high byte locks the pair until the low byte is read or a software start
            if (rd_fire && rd_ok && (rd_idx_w == `ACR_OFF_RESH))
            begin
                hold_q <= 1'b1;
            end
            if (rd_low || start_sw)
            begin
                hold_q <= 1'b0;
            end
            // the set wins over a clear in the same cycle
            if (transfer)
            begin
                resh_q <= {6'h00, res_val[9:8]};
                resl_q <= res_val[7:0];
                done_q <= 1'b1;
            end
            else if (rd_low || start_sw)
            begin
                done_q <= 1'b0;
            end
        end
    end
    // axi read channel, one read in flight
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0;
            o_s_axi_rresp <= `ACR_RESP_OKAY;
        end
        else
        begin
            if (rd_fire)
            begin
                o_s_axi_arready <= 1'b0;
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rresp <= rd_ok ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
                case (rd_idx_w)
                    `ACR_OFF_CFG: o_s_axi_rdata <= {24'h0, cfg_q};
                    `ACR_OFF_TRG: o_s_axi_rdata <= {24'h0, state_q != ST_IDLE,
                        trg_q[6:4], 4'h0};
                    `ACR_OFF_CHM: o_s_axi_rdata <= {24'h0, done_q, chm_q[6:0]};
                    `ACR_OFF_RESH: o_s_axi_rdata <= {24'h0, resh_q};
                    `ACR_OFF_RESL: o_s_axi_rdata <= {24'h0, resl_q};
                    `ACR_OFF_CMPH: o_s_axi_rdata <= {24'h0, cmph_q};
                    `ACR_OFF_CMPL: o_s_axi_rdata <= {24'h0, cmpl_q};
                    `ACR_OFF_PINL: o_s_axi_rdata <= {24'h0, pinl_q};
                    `ACR_OFF_PINH: o_s_axi_rdata <= {24'h0, pinh_q};
                    default: o_s_axi_rdata <= 32'h0;
                endcase
                if (!rd_ok)
                begin
                    o_s_axi_rdata <= 32'h0;
                end
            end
            else if (o_s_axi_rvalid && i_s_axi_rready)
            begin
                o_s_axi_rvalid <= 1'b0;
                o_s_axi_arready <= 1'b1;
            end
        end
    end
    // registered outputs toward the analog front and pads
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_sample_channel <= 5'h1f;
            o_sampling <= 1'b0;
            o_low_power <= 1'b0;
            o_irq <= 1'b0;
            o_pin_analog <= {CHANNELS{1'b0}};
        end
        else
        begin
            o_sample_channel <= chm_q[4:0];
            o_sampling <= (state_q == ST_SAMPLE);
            o_low_power <= cfg_q[`ACR_CFG_LP];
            o_irq <= done_q && chm_q[`ACR_CHM_IEN];
            o_pin_analog <= {pinh_q, pinl_q};
        end
    end
endmodule // acr_regs
`default_nettype wire

/* File: tb/acr_regs_asserts.sv */
// Purpose: port-level checks of the converter register block
// Assumes: byte address is four times the register index
// Notes: write and read targets are latched at the address handshakes
`timescale 1ns/1ps
`default_nettype none
module acr_regs_asserts #(
    parameter CHANNELS = 16
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [31:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [31:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic [1:0] o_s_axi_rresp,
    input wire logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic [4:0] o_sample_channel,
    input wire logic o_sampling,
    input wire logic o_low_power,
    input wire logic [CHANNELS-1:0] o_pin_analog
);
default clocking @(posedge i_sys_clk); endclocking
default disable iff (!i_rst_n);
logic [31:0] wa_q;
logic [31:0] wd_q;
logic [31:0] ra_q;
always_ff @(posedge i_sys_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        wa_q <= 32'h0;
        wd_q <= 32'h0;
        ra_q <= 32'h0;
    end
    else
    begin
        if (i_s_axi_awvalid && o_s_axi_awready)
            wa_q <= i_s_axi_awaddr;
        if (i_s_axi_wvalid && o_s_axi_wready)
            wd_q <= i_s_axi_wdata;
        if (i_s_axi_arvalid && o_s_axi_arready)
            ra_q <= i_s_axi_araddr;
    end
end
sequence wr_done;
    $rose(o_s_axi_bvalid);
endsequence
sequence rd_done;
    $rose(o_s_axi_rvalid);
endsequence
chk_low_power_copy: assert property (wr_done ##0 (wa_q[7:0] == 8'h00)
    |-> ##[0:2] (o_low_power == wd_q[7])) else $error("low power output off");
chk_channel_copy: assert property (wr_done ##0 (wa_q[7:0] == 8'h08)
    |-> ##[0:2] (o_sample_channel == wd_q[4:0])) else $error("channel output off");
chk_pin_low_copy: assert property (wr_done ##0 (wa_q[7:0] == 8'h1c)
    |-> ##[0:2] (o_pin_analog[7:0] == wd_q[7:0])) else $error("pin control off");
chk_trg_zero_bits: assert property (rd_done ##0 (ra_q[7:0] == 8'h04)
    |-> o_s_axi_rdata[3:2] == 2'h0) else $error("unimplemented bits set");
chk_unmapped_read: assert property (rd_done ##0 (ra_q >= 32'h24)
    |-> o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 32'h0) else $error("unmapped read");
chk_sample_min_len: assert property ($rose(o_sampling) |-> o_sampling[*4])
    else $error("sample phase short");
chk_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
chk_write_drop: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("write answer stuck");
chk_read_drop: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("read answer stuck");
endmodule // acr_regs_asserts
bind acr_regs acr_regs_asserts #(.CHANNELS(CHANNELS)) u_acr_chk (
    .i_sys_clk, .i_rst_n, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_bready,
    .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp,
    .o_s_axi_rvalid, .i_s_axi_rready, .o_sample_channel, .o_sampling, .o_low_power,
    .o_pin_analog
);
`default_nettype wire

/* File: tb/acr_regs_tb_top.sv */
// Purpose: register-level tests of the converter register block
// Assumes: byte address is four times the register index
// Notes: conversion clock is the bus clock divided by one throughout
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.vh"
module acr_regs_tb_top;
logic i_sys_clk = 1'b0;
logic i_rst_n = 1'b0;
logic [31:0] i_s_axi_awaddr = 32'h0;
logic i_s_axi_awvalid = 1'b0;
logic [31:0] i_s_axi_wdata = 32'h0;
logic [3:0] i_s_axi_wstrb = 4'hf;
logic i_s_axi_wvalid = 1'b0;
logic i_s_axi_bready = 1'b0;
logic [31:0] i_s_axi_araddr = 32'h0;
logic i_s_axi_arvalid = 1'b0;
logic i_s_axi_rready = 1'b0;
logic i_hw_trigger = 1'b0;
logic i_alt_clk = 1'b0;
logic [9:0] i_analog_code = 10'h3ff;
wire o_s_axi_awready;
wire o_s_axi_wready;
wire [1:0] o_s_axi_bresp;
wire o_s_axi_bvalid;
wire o_s_axi_arready;
wire [31:0] o_s_axi_rdata;
wire [1:0] o_s_axi_rresp;
wire o_s_axi_rvalid;
wire [4:0] o_sample_channel;
wire o_sampling;
wire o_low_power;
wire o_irq;
wire [15:0] o_pin_analog;
int fail_count = 0;
int comparisons = 0;
int cycles = 0;
int run_n = 0;
int smp_len = 0;
acr_regs #(.CHANNELS(16)) dut (
    .i_sys_clk, .i_rst_n, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_hw_trigger,
    .i_alt_clk, .i_analog_code, .o_sample_channel, .o_sampling, .o_low_power, .o_irq,
    .o_pin_analog
);
always #2.5 i_sys_clk = ~i_sys_clk;
task automatic end_of_test;
    if (fail_count == 0 && comparisons > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
        fail_count++;
        $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
endtask
// ready sampled at the edge, so release happens on the next edge only
task automatic wr(input logic [3:0] off, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_s_axi_awaddr <= {26'h0, off, 2'h0};
    i_s_axi_wdata <= {24'h0, d};
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do
    begin
        @(posedge i_sys_clk);
        if (o_s_axi_awready)
            i_s_axi_awvalid <= 1'b0;
        if (o_s_axi_wready)
            i_s_axi_wvalid <= 1'b0;
    end
    while (o_s_axi_bvalid !== 1'b1);
    i_s_axi_bready <= 1'b0;
    chk(o_s_axi_bresp, 32'h0);
endtask
task automatic rd(input logic [3:0] off, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_s_axi_araddr <= {26'h0, off, 2'h0};
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do
    begin
        @(posedge i_sys_clk);
        if (o_s_axi_arready)
            i_s_axi_arvalid <= 1'b0;
    end
    while (o_s_axi_rvalid !== 1'b1);
    i_s_axi_rready <= 1'b0;
    chk(o_s_axi_rdata, {24'h0, e});
    chk(o_s_axi_rresp, (off > 4'h8) ? 32'h2 : 32'h0);
endtask
// waits for the interrupt, then checks the last sample phase length
task automatic conv(input int n);
    repeat (2) @(posedge i_sys_clk);
    while (o_irq !== 1'b1)
        @(posedge i_sys_clk);
    chk(smp_len, n);
endtask
always @(posedge i_sys_clk)
begin
    if (o_sampling === 1'b1)
        run_n <= run_n + 1;
    else if (run_n != 0)
    begin
        smp_len <= run_n;
        run_n <= 0;
    end
end
// generous ceiling, a full run needs a few hundred cycles
always @(posedge i_sys_clk)
begin
    cycles++;
    if (cycles == 20000)
    begin
        fail_count++;
        end_of_test();
    end
end
initial
begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(`ACR_OFF_CHM, 8'h1f);
    chk(o_sample_channel, 32'h1f);
    wr(`ACR_OFF_TRG, 8'h40);
    wr(`ACR_OFF_CHM, 8'h01);
    repeat (40) @(posedge i_sys_clk);
    rd(`ACR_OFF_CHM, 8'h01);
    i_hw_trigger <= 1'b1;
    repeat (40) @(posedge i_sys_clk);
    rd(`ACR_OFF_CHM, 8'h81);
    chk(smp_len, 32'h4);
    chk(o_irq, 32'h0);
    rd(`ACR_OFF_RESH, 8'h00);
    rd(`ACR_OFF_RESL, 8'hff);
    i_hw_trigger <= 1'b0;
    wr(`ACR_OFF_CFG, 8'h98);
    rd(`ACR_OFF_CFG, 8'h98);
    chk(o_low_power, 32'h1);
    wr(`ACR_OFF_TRG, 8'h0c);
    rd(`ACR_OFF_TRG, 8'h00);
    i_analog_code <= 10'h2a5;
    wr(`ACR_OFF_CHM, 8'h41);
    conv(24);
    chk(o_sample_channel, 32'h01);
    rd(`ACR_OFF_CHM, 8'hc1);
    rd(`ACR_OFF_RESH, 8'h02);
    rd(`ACR_OFF_RESL, 8'ha5);
    rd(`ACR_OFF_CHM, 8'h41);
    chk(o_irq, 32'h0);
    wr(`ACR_OFF_CFG, 8'h08);
    wr(`ACR_OFF_CMPH, 8'h01);
    wr(`ACR_OFF_CMPL, 8'h00);
    wr(`ACR_OFF_TRG, 8'h30);
    wr(`ACR_OFF_CHM, 8'h41);
    conv(4);
    rd(`ACR_OFF_RESH, 8'h01);
    rd(`ACR_OFF_RESL, 8'ha5);
    wr(`ACR_OFF_TRG, 8'h20);
    wr(`ACR_OFF_CHM, 8'h41);
    repeat (40) @(posedge i_sys_clk);
    chk(o_irq, 32'h0);
    rd(`ACR_OFF_CHM, 8'h41);
    rd(`ACR_OFF_RESL, 8'ha5);
    wr(`ACR_OFF_TRG, 8'h00);
    wr(`ACR_OFF_CHM, 8'h61);
    conv(4);
    rd(`ACR_OFF_RESH, 8'h02);
    i_analog_code <= 10'h155;
    repeat (60) @(posedge i_sys_clk);
    rd(`ACR_OFF_RESL, 8'ha5);
    conv(4);
    rd(`ACR_OFF_RESH, 8'h01);
    rd(`ACR_OFF_RESL, 8'h55);
    rd(`ACR_OFF_TRG, 8'h80);
    wr(`ACR_OFF_PINL, 8'h02);
    wr(`ACR_OFF_PINH, 8'h80);
    rd(`ACR_OFF_PINL, 8'h02);
    chk(o_pin_analog, 32'h8002);
    rd(4'h9, 8'h00);
    end_of_test();
end
endmodule // acr_regs_tb_top
`default_nettype wire
